// >>> src/adc_link_defs.vh
// Constants for the converter serial output and power control block
`ifndef ADC_LINK_DEFS_VH
`define ADC_LINK_DEFS_VH

// System clock rate
`define CLK_MHZ 50
// Duty stabilizer: least sample clock rate, relock wait (ns, least)
`define DCS_MIN_MHZ 20
`define DCS_RELOCK_NS 1500
`define DCS_RELOCK_CYC ((`DCS_RELOCK_NS * `CLK_MHZ + 999) / 1000)
// Longest sample period, in cycles, at which the loop still works
`define DCS_MAX_PERIOD_CYC (`CLK_MHZ / `DCS_MIN_MHZ)
// Wake-up after pin power-down (us) and after standby (ns)
`define PD_WAKE_US 375
`define PD_WAKE_CYC (`PD_WAKE_US * `CLK_MHZ)
`define STBY_WAKE_NS 600
`define STBY_WAKE_CYC ((`STBY_WAKE_NS * `CLK_MHZ) / 1000)
// Sample word layout
`define SAMPLE_BITS 8
`define LANES 4
`define FIFO_DEPTH 16
// Bits per frame where the frame clock is high
`define FRAME_HIGH_BITS 3'h4
// Offset binary landmarks
`define CODE_POS_FULL 8'hFF
`define CODE_MID 8'h80
`define CODE_NEG_FULL 8'h00

`endif

// >>> src/adc_serial_output_power_control.v
// Converter clock, power state and serial lane output control, with its sample FIFO
`timescale 1ns/1ps
`include "adc_link_defs.vh"
// Contract
// - Stabilizer regenerates falling edge, 50% duty
// - Stabilizer unusable below 20 MHz sample clock
// - Unlocked stabilizer is bypassed, input duty used
// - Power-down pin high stops, low resumes
// - Power-down puts serial drivers in high-Z
// - Settings survive power-down, no reset needed
// - Per-channel power-down; standby keeps PLL, 600ns
// - Standard swing at reset; pin/setting reduces
// - One setting boosts drive of all lanes
// - Offset binary default, twos complement selectable
// - Offset binary: FF, 80, 7F, 00 landmarks
// - Each channel own lane, eight bits/sample
// - Setting moves PLL range down to 5 MSPS
// - Sample taken on sample clock rising edge
// - Data clock 4x, frame clock 1x sample
// - Serialized sample sent MSB first by default

// Synchronous FIFO with valid/ready on both sides
module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire empty;
  wire full;

  // Extra pointer bit tells full from empty
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready = ~full & ~clear;
  assign out_valid = ~empty & ~clear;
  assign out_data = mem[rd_q[AW-1:0]];

  // Pointer update; clear empties the buffer
  always @(posedge clk) begin
    if (!rst_n || clear) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Storage has no reset; only pointers matter
  always @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule // sample_fifo

module adc_serial_output_power_control #(
  parameter PD_WAKE_CYCLES = `PD_WAKE_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire sample_clk,
  input wire [7:0] ch0_code,
  input wire [7:0] ch1_code,
  input wire [7:0] ch2_code,
  input wire [7:0] ch3_code,
  input wire power_down_pin,
  input wire serial_io_output_mode_pin,
  input wire link_hold,
  input wire dcs_enable,
  input wire standby_cfg,
  input wire [3:0] chan_pd_cfg,
  input wire low_swing_cfg,
  input wire drive_boost_cfg,
  input wire twos_comp_cfg,
  input wire lsb_first_cfg,
  input wire low_rate_pll_cfg,
  output reg internal_clk,
  output reg dcs_locked,
  output reg dcs_active,
  output reg pll_running,
  output reg pll_low_range,
  output reg low_swing,
  output reg drive_boost,
  output wire sample_ready,
  output reg [3:0] lane_out,
  output reg [3:0] lane_oe,
  output reg data_clock_out,
  output reg frame_clock_out,
  output reg clk_oe,
  output reg link_running
);
  localparam ST_RUN = 2'h0;
  localparam ST_PD = 2'h1;
  localparam ST_STBY = 2'h2;
  localparam ST_WAKE = 2'h3;
  localparam integer STBY_WAKE = `STBY_WAKE_CYC;

  // Offset binary in, optionally twos complement out
  function [7:0] fmt_code;
    input [7:0] c;
    input twos;
    begin
      fmt_code = {c[7] ^ twos, c[6:0]};
    end
  endfunction

  // Bit of a lane for position k of the frame
  function lane_bit;
    input [7:0] w;
    input [2:0] k;
    input lsb;
    begin
      lane_bit = lsb ? w[k] : w[3'h7 - k];
    end
  endfunction

  reg [2:0] sclk_q;
  reg [31:0] code_m_q;
  reg [31:0] code_s_q;
  reg [1:0] pd_q;
  reg [1:0] odm_q;
  reg [1:0] hold_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] wake_q;
  reg [7:0] per_cnt_q;
  reg [7:0] per_q;
  reg [7:0] relock_q;
  reg [7:0] half_q;
  reg [2:0] bit_q;
  reg act_q;
  reg [31:0] word_q;
  reg [31:0] push_q;
  reg push_v_q;
  wire sclk_rise;
  wire run;
  wire [31:0] fifo_data;
  wire fifo_valid;
  wire load;
  wire busy;
  integer j;
  integer n;

  // Two-flop synchronisers; third flop only for edge finding
  always @(posedge clk) begin
    if (!rst_n) begin
      sclk_q <= 3'h0;
      code_m_q <= 32'h0;
      code_s_q <= 32'h0;
      pd_q <= 2'h0;
      odm_q <= 2'h0;
      hold_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sample_clk};
      code_m_q <= {ch3_code, ch2_code, ch1_code, ch0_code};
      code_s_q <= code_m_q;
      pd_q <= {pd_q[0], power_down_pin};
      odm_q <= {odm_q[0], serial_io_output_mode_pin};
      hold_q <= {hold_q[0], link_hold};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign run = (state_q == ST_RUN);

  // power state selection; pin wins over standby
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (pd_q[1]) begin
          state_d = ST_PD;
        end else if (standby_cfg) begin
          state_d = ST_STBY;
        end
      end
      ST_PD: begin
        if (!pd_q[1]) begin
          state_d = ST_WAKE;
        end
      end
      ST_STBY: begin
        if (pd_q[1]) begin
          state_d = ST_PD;
        end else if (!standby_cfg) begin
          state_d = ST_WAKE;
        end
      end
      default: begin
        if (pd_q[1]) begin
          state_d = ST_PD;
        end else if (standby_cfg) begin
          state_d = ST_STBY;
        end else if (wake_q == 16'h0) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  // wake wait; PLL kept alive in standby shortens it
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
      wake_q <= 16'h0;
      pll_running <= 1'b1;
    end else begin
      state_q <= state_d;
      pll_running <= (state_d != ST_PD);
      if (state_q == ST_PD) begin
        wake_q <= PD_WAKE_CYCLES[15:0];
      end else if (state_q == ST_STBY) begin
        wake_q <= STBY_WAKE[15:0];
      end else if (wake_q != 16'h0) begin
        wake_q <= wake_q - 16'h1;
      end
    end
  end

  // measure sample period; slow clocks never lock
  always @(posedge clk) begin
    if (!rst_n) begin
      per_cnt_q <= 8'h0;
      per_q <= 8'hFF;
      relock_q <= 8'h0;
      dcs_locked <= 1'b0;
    end else begin
      if (sclk_rise) begin
        per_cnt_q <= 8'h1;
        per_q <= per_cnt_q;
      end else if (per_cnt_q != 8'hFF) begin
        per_cnt_q <= per_cnt_q + 8'h1;
      end
      // relock wait restarts on any period change
      if (!dcs_enable || per_q > `DCS_MAX_PERIOD_CYC || per_q == 8'h0) begin
        relock_q <= 8'h0;
        dcs_locked <= 1'b0;
      end else if (sclk_rise && per_cnt_q != per_q) begin
        relock_q <= 8'h0;
        dcs_locked <= 1'b0;
      end else if (relock_q == `DCS_RELOCK_CYC) begin
        dcs_locked <= 1'b1;
      end else begin
        relock_q <= relock_q + 8'h1;
      end
    end
  end

  // regenerated clock is high for half the period
  always @(posedge clk) begin
    if (!rst_n) begin
      half_q <= 8'h0;
      internal_clk <= 1'b0;
      dcs_active <= 1'b0;
    end else begin
      dcs_active <= dcs_enable & dcs_locked;
      if (dcs_enable && dcs_locked) begin
        if (sclk_rise) begin
          half_q <= {1'b0, per_q[7:1]};
          internal_clk <= 1'b1;
        end else if (half_q <= 8'h1) begin
          internal_clk <= 1'b0;
        end else begin
          half_q <= half_q - 8'h1;
        end
      end else begin
        internal_clk <= sclk_q[1];
      end
    end
  end

  // settings are ports held by their source, untouched by power states
  always @(posedge clk) begin
    if (!rst_n) begin
      low_swing <= 1'b0;
      drive_boost <= 1'b0;
      pll_low_range <= 1'b0;
    end else begin
      // standard swing until pin or setting asks
      low_swing <= low_swing_cfg | odm_q[1];
      // one boost for all four lanes
      drive_boost <= drive_boost_cfg;
      // lower PLL range for slow sample rates
      pll_low_range <= low_rate_pll_cfg;
    end
  end

  // coding applied as each sample is captured
  always @(posedge clk) begin
    if (!rst_n) begin
      push_q <= 32'h0;
      push_v_q <= 1'b0;
    end else begin
      push_v_q <= run & sclk_rise;
      for (j = 0; j < 4; j = j + 1) begin
        push_q[j*8 +: 8] <= chan_pd_cfg[j] ? 8'h00 :
          fmt_code(code_s_q[j*8 +: 8], twos_comp_cfg);
      end
    end
  end

  // Words dropped when the buffer is full; sample_ready shows it
  sample_fifo #(
    .WIDTH(`SAMPLE_BITS * `LANES),
    .DEPTH(`FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .clear(~run),
    .in_data(push_q),
    .in_valid(push_v_q),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(load)
  );

  // new words only start at a frame boundary
  assign load = run & fifo_valid & ~hold_q[1] & (~act_q | (bit_q == 3'h7));
  // Word in flight; ends after bit 7, and leaving RUN cuts it at once
  assign busy = load | (run & act_q & (bit_q != 3'h7));

  // bit counter shared by all four lanes
  always @(posedge clk) begin
    if (!rst_n || !run) begin
      bit_q <= 3'h0;
      act_q <= 1'b0;
      word_q <= 32'h0;
    end else if (load) begin
      bit_q <= 3'h0;
      act_q <= 1'b1;
      word_q <= fifo_data;
    end else if (act_q && bit_q == 3'h7) begin
      act_q <= 1'b0;
      bit_q <= 3'h0;
    end else if (act_q) begin
      bit_q <= bit_q + 3'h1;
    end
  end

  // MSB first unless LSB-first is set
  always @(posedge clk) begin
    if (!rst_n) begin
      lane_out <= 4'h0;
      lane_oe <= 4'h0;
      data_clock_out <= 1'b0;
      frame_clock_out <= 1'b0;
      clk_oe <= 1'b0;
      link_running <= 1'b0;
    end else begin
      for (n = 0; n < 4; n = n + 1) begin
        lane_out[n] <= busy ?
          lane_bit(load ? fifo_data[n*8 +: 8] : word_q[n*8 +: 8],
            load ? 3'h0 : bit_q + 3'h1, lsb_first_cfg) : 1'b0;
        // drivers released in power-down and standby
        lane_oe[n] <= run & ~chan_pd_cfg[n];
      end
      clk_oe <= run;
      link_running <= busy;
      // one toggle per bit: four data clocks per frame
      data_clock_out <= busy ? ~data_clock_out : 1'b0;
      frame_clock_out <= load ? 1'b1 :
        (busy && (bit_q + 3'h1) < `FRAME_HIGH_BITS);
    end
  end
endmodule // adc_serial_output_power_control

// >>> tb/adc_link_sva.sv
// Assertion checker for the converter link control block
`timescale 1ns/1ps
module adc_link_sva (
  input wire clk,
  input wire rst_n,
  input wire sample_clk,
  input wire internal_clk,
  input wire power_down_pin,
  input wire serial_io_output_mode_pin,
  input wire low_swing_cfg,
  input wire drive_boost_cfg,
  input wire low_rate_pll_cfg,
  input wire dcs_locked,
  input wire dcs_active,
  input wire pll_low_range,
  input wire low_swing,
  input wire drive_boost,
  input wire [3:0] lane_oe,
  input wire data_clock_out,
  input wire frame_clock_out,
  input wire clk_oe,
  input wire link_running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Pin sync, state and output flops: five samples before demanding high-Z
  pd_hiz_a: assert property (power_down_pin [*5] |-> lane_oe == 4'h0 && !clk_oe)
    else $error("outputs driven in power-down");
  frame_shape_a: assert property ($rose(link_running) |->
    frame_clock_out [*4] ##1 !frame_clock_out [*4])
    else $error("frame clock shape wrong");
  // Bypassed clock is the synchronised pin, three cycles late
  dcs_bypass_a: assert property (!dcs_locked [*2] |-> internal_clk == $past(sample_clk, 3))
    else $error("bypass clock not following input");
  dco_run_a: assert property (link_running |-> data_clock_out != $past(data_clock_out))
    else $error("data clock not toggling");
  idle_quiet_a: assert property (!link_running |-> !data_clock_out && !frame_clock_out)
    else $error("clocks active while idle");
  swing_low_a: assert property (
    (!low_swing_cfg && !serial_io_output_mode_pin) [*4] |-> !low_swing)
    else $error("reduced swing without request");
  swing_set_a: assert property (low_swing_cfg |=> low_swing)
    else $error("reduced swing not applied");
  boost_a: assert property ($past(rst_n) |-> drive_boost == $past(drive_boost_cfg))
    else $error("drive boost not following setting");
  pll_range_a: assert property ($past(rst_n) |-> pll_low_range == $past(low_rate_pll_cfg))
    else $error("pll range not following setting");
  dcs_gate_a: assert property (!dcs_locked |=> !dcs_active)
    else $error("stabilizer used while unlocked");
  // Main scenarios
  c_word: cover property ($rose(link_running));
  c_pd: cover property (power_down_pin [*4]);
  c_swing: cover property ($rose(low_swing));
endmodule // adc_link_sva

bind adc_serial_output_power_control adc_link_sva i_sva (.clk(clk), .rst_n(rst_n),
  .sample_clk(sample_clk), .internal_clk(internal_clk),
  .power_down_pin(power_down_pin), .serial_io_output_mode_pin(serial_io_output_mode_pin),
  .low_swing_cfg(low_swing_cfg), .drive_boost_cfg(drive_boost_cfg),
  .low_rate_pll_cfg(low_rate_pll_cfg), .dcs_locked(dcs_locked), .dcs_active(dcs_active),
  .pll_low_range(pll_low_range), .low_swing(low_swing), .drive_boost(drive_boost),
  .lane_oe(lane_oe), .data_clock_out(data_clock_out), .frame_clock_out(frame_clock_out),
  .clk_oe(clk_oe), .link_running(link_running));

// >>> tb/lane_receiver.sv
// Receiver model at the far end of the serial lanes
`timescale 1ns/1ps
module lane_receiver (
  input wire clk,
  input wire rst_n,
  input wire stall,
  input wire [3:0] lane_out,
  input wire [3:0] lane_oe,
  input wire data_clock_out,
  input wire frame_clock_out,
  output reg link_hold,
  output reg [35:0] word,
  output reg word_valid
);
  reg [31:0] sh;
  reg [2:0] cnt;
  reg dco_q;
  reg frm_q;
  wire [3:0] bits;
  wire [31:0] sh_d;
  wire frame_start;
  // Undriven lanes read as 0, as if pulled down
  assign bits = lane_oe & lane_out;
  assign sh_d = {sh[30:24], bits[3], sh[22:16], bits[2], sh[14:8], bits[1], sh[6:0], bits[0]};
  // Frame clock rise marks bit 0 of a word
  assign frame_start = frame_clock_out & ~frm_q;
  // a bit on every data clock edge, rising and falling
  always @(posedge clk) begin
    word_valid <= 1'b0;
    link_hold <= stall;
    if (!rst_n) begin
      cnt <= 3'h0;
      sh <= 32'h0;
      dco_q <= 1'b0;
      frm_q <= 1'b0;
    end else begin
      dco_q <= data_clock_out;
      frm_q <= frame_clock_out;
      if (data_clock_out != dco_q) begin
        sh <= sh_d;
        cnt <= frame_start ? 3'h1 : cnt + 3'h1;
        if (!frame_start && cnt == 3'h7) begin
          word <= {lane_oe, sh_d};
          word_valid <= 1'b1;
        end
      end
    end
  end
endmodule // lane_receiver

// >>> tb/adc_serial_output_power_control_tb_top.sv
// Self-checking bench for the converter link control block
`timescale 1ns/1ps
module adc_serial_output_power_control_tb_top;
  reg clk = 1'b0, rst_n = 1'b0, sample_clk = 1'b0, run = 1'b0, stall = 1'b0;
  reg power_down_pin = 1'b0, serial_io_output_mode_pin = 1'b0, dcs_enable = 1'b1;
  reg standby_cfg = 1'b0, low_swing_cfg = 1'b0, drive_boost_cfg = 1'b0;
  reg twos_comp_cfg = 1'b0, lsb_first_cfg = 1'b0, low_rate_pll_cfg = 1'b0;
  reg [3:0] chan_pd_cfg = 4'h0, m;
  reg [31:0] codes = 32'h0;
  reg [15:0] seed = 16'h7AAC;
  wire link_hold, dcs_locked, dcs_active, pll_running, pll_low_range, low_swing;
  wire drive_boost, sample_ready, data_clock_out, frame_clock_out, clk_oe, link_running;
  wire word_valid;
  wire [3:0] lane_out, lane_oe;
  wire [35:0] word;
  reg [35:0] exp_q[$];
  integer fails = 0, n_compared = 0, cyc = 0, i;

  always #10 clk = ~clk;
  // Sample clock stands still while run is low
  // one fixed rate, no relock
  always begin
    #80;
    if (run) sample_clk = ~sample_clk;
  end

  adc_serial_output_power_control #(.PD_WAKE_CYCLES(20)) i_dut (.clk, .rst_n, .sample_clk,
    .ch0_code(codes[7:0]), .ch1_code(codes[15:8]), .ch2_code(codes[23:16]),
    .ch3_code(codes[31:24]), .power_down_pin, .serial_io_output_mode_pin, .link_hold,
    .dcs_enable, .standby_cfg, .chan_pd_cfg, .low_swing_cfg, .drive_boost_cfg,
    .twos_comp_cfg, .lsb_first_cfg, .low_rate_pll_cfg, .internal_clk(), .dcs_locked,
    .dcs_active, .pll_running, .pll_low_range, .low_swing, .drive_boost, .sample_ready,
    .lane_out, .lane_oe, .data_clock_out, .frame_clock_out, .clk_oe, .link_running);

  lane_receiver i_rx (.clk, .rst_n, .stall, .lane_out, .lane_oe, .data_clock_out,
    .frame_clock_out, .link_hold, .word, .word_valid);

  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected lane word from codes and settings
  function [35:0] expw(input integer dummy);
    integer j;
    reg [7:0] c;
    begin
      expw = {~chan_pd_cfg, 32'h0};
      for (j = 0; j < 4; j = j + 1) begin
        c = codes[j*8 +: 8] ^ (twos_comp_cfg ? 8'h80 : 8'h00);
        if (lsb_first_cfg) c = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], c[7]};
        if (chan_pd_cfg[j]) c = 8'h00;
        expw[j*8 +: 8] = c;
      end
    end
  endfunction

  task check(input [35:0] e, input [35:0] g);
    begin
      n_compared = n_compared + 1;
      // Unknown received bits never pass
      if (e !== g || ^g === 1'bx) begin
        fails = fails + 1;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  // Runs n sample edges, noting a word for each when en is set
  task send(input integer n, input en);
    begin
      run = 1'b1;
      repeat (n) begin
        @(posedge sample_clk);
        if (en) exp_q.push_back(expw(0));
      end
      run = 1'b0;
      tick(1);
    end
  endtask

  task drain;
    integer w;
    begin
      for (w = 0; w < 600 && exp_q.size() > 0; w = w + 1) @(posedge clk);
      tick(12);
      check(36'h0, {4'h0, exp_q.size()});
    end
  endtask

  task results;
    begin
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Oldest noted word against each received word
  always @(posedge clk) begin
    if (word_valid) check(exp_q.size() ? exp_q.pop_front() : ~word, word);
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      results;
    end
  end

  initial begin
    tick(10);
    rst_n = 1'b1;
    codes = 32'h007F80FF;
    for (i = 0; i < 2; i = i + 1) begin
      twos_comp_cfg = i[0];
      tick(4);
      send(3, 1'b1);
      drain;
    end
    // random codes, bit order and lane power-down
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(lfsr(seed));
      codes = {seed, lfsr(seed)};
      {lsb_first_cfg, twos_comp_cfg, chan_pd_cfg} = seed[5:0];
      tick(4);
      send(3, 1'b1);
      drain;
    end
    power_down_pin = 1'b1;
    tick(6);
    check(36'h0, {30'h0, pll_running, clk_oe, lane_oe});
    send(2, 1'b0);
    power_down_pin = 1'b0;
    tick(40);
    send(2, 1'b1);
    drain;
    standby_cfg = 1'b1;
    tick(6);
    check(36'h20, {30'h0, pll_running, clk_oe, lane_oe});
    send(2, 1'b0);
    standby_cfg = 1'b0;
    tick(40);
    send(2, 1'b1);
    drain;
    // swing, boost and pll range, one at a time
    for (i = 0; i < 5; i = i + 1) begin
      m = 4'h1 << i;
      {serial_io_output_mode_pin, low_swing_cfg, drive_boost_cfg, low_rate_pll_cfg} = m;
      tick(6);
      check({33'h0, m[3] | m[2], m[1], m[0]},
        {32'h0, dcs_active, low_swing, drive_boost, pll_low_range});
    end
    // receiver stalls until the buffer refuses
    stall = 1'b1;
    tick(6);
    send(16, 1'b1);
    send(4, 1'b0);
    tick(4);
    check(36'h0, {35'h0, sample_ready});
    stall = 1'b0;
    drain;
    results;
  end
endmodule // adc_serial_output_power_control_tb_top
